// [pcbc_pkg.sv]
// constants and types shared by the passive cell balance control block
package pcbc_pkg;
    // ------------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_ENABLE   = 8'h00;
    localparam logic [7:0] OFS_CONFIG   = 8'h04;
    localparam logic [7:0] OFS_TEST     = 8'h08;
    localparam logic [7:0] OFS_FAULT    = 8'h0c;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
    localparam logic [7:0] OFS_STATUS   = 8'h18;
    // ------------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------------
    localparam int         NUM_CELLS     = 16;
    localparam int         CFG_CONT_BIT  = 0;
    localparam int         CFG_TIME_LSB  = 8;
    localparam int         TIME_W        = 8;
    localparam int         TST_SQZ_BIT   = 0;
    localparam logic       TST_SQZ_RST   = 1'b1;
    localparam int         FLT_CKF_BIT   = 0;
    localparam int         FLT_CKE_BIT   = 1;
    localparam int         IRQ_W         = 3;
    localparam int         IRQ_STOP_BIT  = 0;
    localparam int         IRQ_EXP_BIT   = 1;
    localparam int         IRQ_CKE_BIT   = 2;
    localparam int         STS_PWR_BIT   = 0;
    localparam int         STS_LOCK_BIT  = 1;
    localparam int         STS_SQZ_BIT   = 2;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ    = 2'h3;
    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLK_FREQ_HZ  = 50_000_000;
    localparam int TICK_TIME_MS = 1000;
    localparam int TICK_CYCLES  = TICK_TIME_MS * (CLK_FREQ_HZ / 1000);
    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic {TMR_IDLE, TMR_RUN} pcbc_tmr_state_t;
endpackage : pcbc_pkg

// [pcbc_drive_cell.sv]
// one balance driver output, selecting the upper or lower sense rail
`timescale 1ns/10ps
module pcbc_drive_cell
    import pcbc_pkg::*;
(
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic reset_n,
    // control
    input  wire logic enable_bit,
    input  wire logic power_on,
    // driver
    output logic      balance_drive_out
);
    // high selects the cell's upper rail, low the next lower rail
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            balance_drive_out <= 1'b0;
        end else begin
            balance_drive_out <= enable_bit & power_on;
        end
    end

    drive_on_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        $rose(enable_bit) && power_on |=> balance_drive_out)
        else $error("driver did not switch to the upper rail");
    drive_off_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        !enable_bit |=> !balance_drive_out)
        else $error("driver did not release to the lower rail");
endmodule : pcbc_drive_cell

// [pcbc_bal_timer.sv]
// balance duration timer: counts ticks and pulses when the time runs out
`timescale 1ns/10ps
module pcbc_bal_timer
    import pcbc_pkg::*;
#(
    parameter int TICK_LEN = TICK_CYCLES,
    parameter int DUR_W    = TIME_W
) (
    // clock and reset
    input  wire logic             sys_clk,
    input  wire logic             reset_n,
    // control
    input  wire logic             start,
    input  wire logic             run,
    input  wire logic [DUR_W-1:0] duration,
    // event
    output logic                  expire
);
    localparam int PW = (TICK_LEN > 1) ? $clog2(TICK_LEN) : 1;
    localparam logic [PW-1:0] PRE_LAST = PW'(TICK_LEN - 1);

    pcbc_tmr_state_t  state_reg;
    logic [PW-1:0]    pre_reg;
    logic [DUR_W-1:0] left_reg;

    generate
        if (TICK_LEN < 1) begin : g_bad
            $error("TICK_LEN must be at least one");
        end
    endgenerate

    // a zero duration means balance without a time limit
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= TMR_IDLE;
            pre_reg   <= '0;
            left_reg  <= '0;
            expire    <= 1'b0;
        end else begin
            expire <= 1'b0;
            case (state_reg)
                TMR_IDLE: begin
                    if (start && duration != '0) begin
                        state_reg <= TMR_RUN;
                        pre_reg   <= '0;
                        left_reg  <= duration;
                    end
                end
                TMR_RUN: begin
                    if (!run) begin
                        state_reg <= TMR_IDLE;
                    end else if (start) begin
                        pre_reg  <= '0;
                        left_reg <= duration;
                        if (duration == '0) begin
                            state_reg <= TMR_IDLE;
                        end
                    end else if (pre_reg == PRE_LAST) begin
                        pre_reg  <= '0;
                        left_reg <= left_reg - 1'b1;
                        if (left_reg == DUR_W'(1)) begin
                            expire    <= 1'b1;
                            state_reg <= TMR_IDLE;
                        end
                    end else begin
                        pre_reg <= pre_reg + 1'b1;
                    end
                end
                default: state_reg <= TMR_IDLE;
            endcase
        end
    end
endmodule : pcbc_bal_timer

// [pcbc_balance_ctrl.sv]
// passive cell balance control with AHB-Lite register slave
`timescale 1ns/10ps
// Function
// - each of sixteen drivers goes to its upper rail when its enable bit is set
// - a cleared enable bit drops that driver to the lower rail
// - without continue-on-fault a device fault or pending fault flags clear all enable bits
// - a user checksum fault alone never stops balancing
// - after a stop balancing stays off until software writes the enable register again while stop_lock is low
// - with continue-on-fault, faults leave enable and config registers alone
// - every change of the enable register sets the checksum error flag
// - balancing circuitry powered only while some enable bit is set
module pcbc_balance_ctrl
    import pcbc_pkg::*;
#(
    parameter int N_CELLS  = NUM_CELLS,
    parameter int TICK_LEN = TICK_CYCLES
) (
    // clock and reset
    input  wire logic               sys_clk,
    input  wire logic               reset_n,
    // AHB-Lite slave
    input  wire logic               hsel,
    input  wire logic [31:0]        haddr,
    input  wire logic [1:0]         htrans,
    input  wire logic               hwrite,
    input  wire logic [2:0]         hsize,
    input  wire logic [31:0]        hwdata,
    input  wire logic               hready,
    output logic                    hreadyout,
    output logic                    hresp,
    output logic [31:0]             hrdata,
    // fault sources from the device's monitors
    input  wire logic               device_fault_in,
    input  wire logic               fault_flags_pending,
    input  wire logic               user_checksum_fault,
    // balance drivers and power gate
    output logic [N_CELLS-1:0]      balance_drive_out,
    output logic                    balance_power_en,
    // status
    output logic                    user_checksum_error_flag,
    output logic                    open_wire_squeeze_enable,
    output logic                    irq
);
    // ------------------------------------------------------------------
    // parameter checks
    // ------------------------------------------------------------------
    generate
        if (N_CELLS < 1 || N_CELLS > 32) begin : g_bad_cells
            $error("N_CELLS must lie between 1 and 32");
        end
    endgenerate

    // ------------------------------------------------------------------
    // bus address phase capture
    // ------------------------------------------------------------------
    logic              ph_wr_reg;
    logic [7:0]        ph_addr_reg;
    logic              addr_ok;
    logic              wr_enable;
    logic              wr_config;
    logic              wr_test;
    logic              wr_fault;
    logic              wr_istat;
    logic              wr_imask;

    assign addr_ok   = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
    // single-cycle answer, never an error
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ph_wr_reg   <= 1'b0;
            ph_addr_reg <= '0;
        end else if (hready) begin
            ph_wr_reg   <= addr_ok && hwrite;
            ph_addr_reg <= haddr[7:0];
        end
    end

    assign wr_enable = ph_wr_reg && ph_addr_reg == OFS_ENABLE;
    assign wr_config = ph_wr_reg && ph_addr_reg == OFS_CONFIG;
    assign wr_test   = ph_wr_reg && ph_addr_reg == OFS_TEST;
    assign wr_fault  = ph_wr_reg && ph_addr_reg == OFS_FAULT;
    assign wr_istat  = ph_wr_reg && ph_addr_reg == OFS_IRQ_STAT;
    assign wr_imask  = ph_wr_reg && ph_addr_reg == OFS_IRQ_MASK;

    // ------------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------------
    logic [N_CELLS-1:0] balance_enable_reg;
    logic [N_CELLS-1:0] balance_enable_next;
    logic               continue_on_fault;
    logic [TIME_W-1:0]  balance_time_field;
    logic               stop_lock;
    logic               timer_start;
    logic               timer_expire;
    logic               enable_changed;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            continue_on_fault  <= 1'b0;
            balance_time_field <= '0;
        end else if (wr_config) begin
            continue_on_fault  <= hwdata[CFG_CONT_BIT];
            balance_time_field <= hwdata[CFG_TIME_LSB +: TIME_W];
        end
    end

    // software has to clear this before balancing; the block only reports it
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            open_wire_squeeze_enable <= TST_SQZ_RST;
        end else if (wr_test) begin
            open_wire_squeeze_enable <= hwdata[TST_SQZ_BIT];
        end
    end

    // ------------------------------------------------------------------
    // balance enable register and fault response
    // ------------------------------------------------------------------
    // the checksum fault is not an input of stop_lock, so it can never stop balancing
    assign stop_lock = !continue_on_fault
                       && (device_fault_in || fault_flags_pending);

    always_comb begin
        balance_enable_next = balance_enable_reg;
        if (timer_expire) begin
            balance_enable_next = '0;
        end
        if (wr_enable) begin
            balance_enable_next = hwdata[N_CELLS-1:0];
        end
        // fault clear beats a write; the old selection is lost for good
        if (stop_lock) begin
            balance_enable_next = '0;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            balance_enable_reg <= '0;
        end else begin
            balance_enable_reg <= balance_enable_next;
        end
    end

    assign enable_changed = balance_enable_next != balance_enable_reg;
    assign timer_start    = wr_enable && !stop_lock && hwdata[N_CELLS-1:0] != '0;

    pcbc_bal_timer #(
        .TICK_LEN (TICK_LEN),
        .DUR_W    (TIME_W)
    ) u_timer (
        .sys_clk  (sys_clk),
        .reset_n  (reset_n),
        .start    (timer_start),
        .run      (balance_enable_reg != '0),
        .duration (balance_time_field),
        .expire   (timer_expire)
    );

    // ------------------------------------------------------------------
    // checksum error flag
    // ------------------------------------------------------------------
    // a change in the clearing cycle still leaves the flag set
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            user_checksum_error_flag <= 1'b0;
        end else if (enable_changed) begin
            user_checksum_error_flag <= 1'b1;
        end else if (wr_fault && hwdata[FLT_CKE_BIT]) begin
            user_checksum_error_flag <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // power gate and drivers
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            balance_power_en <= 1'b0;
        end else begin
            balance_power_en <= balance_enable_next != '0;
        end
    end

    generate
        for (genvar c = 0; c < N_CELLS; c++) begin : g_drv
            pcbc_drive_cell u_cell (
                .sys_clk           (sys_clk),
                .reset_n           (reset_n),
                .enable_bit        (balance_enable_reg[c]),
                .power_on          (balance_power_en),
                .balance_drive_out (balance_drive_out[c])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // interrupts
    // ------------------------------------------------------------------
    logic [IRQ_W-1:0] irq_stat_reg;
    logic [IRQ_W-1:0] irq_mask_reg;
    logic [IRQ_W-1:0] irq_set;
    logic [IRQ_W-1:0] irq_clr;

    always_comb begin
        irq_set               = '0;
        irq_set[IRQ_STOP_BIT] = stop_lock && balance_enable_reg != '0;
        irq_set[IRQ_EXP_BIT]  = timer_expire;
        irq_set[IRQ_CKE_BIT]  = enable_changed;
        irq_clr               = wr_istat ? hwdata[IRQ_W-1:0] : '0;
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_stat_reg <= '0;
        end else begin
            irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_mask_reg <= '0;
        end else if (wr_imask) begin
            irq_mask_reg <= hwdata[IRQ_W-1:0];
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(((irq_stat_reg & ~irq_clr) | irq_set) & irq_mask_reg);
        end
    end

    // ------------------------------------------------------------------
    // read data
    // ------------------------------------------------------------------
    logic [31:0] rd_value;

    always_comb begin
        rd_value = '0;
        case (haddr[7:0])
            OFS_ENABLE:   rd_value[N_CELLS-1:0] = balance_enable_reg;
            OFS_CONFIG: begin
                rd_value[CFG_CONT_BIT]               = continue_on_fault;
                rd_value[CFG_TIME_LSB +: TIME_W]     = balance_time_field;
            end
            OFS_TEST:     rd_value[TST_SQZ_BIT] = open_wire_squeeze_enable;
            OFS_FAULT: begin
                rd_value[FLT_CKF_BIT] = user_checksum_fault;
                rd_value[FLT_CKE_BIT] = user_checksum_error_flag;
            end
            OFS_IRQ_STAT: rd_value[IRQ_W-1:0] = irq_stat_reg;
            OFS_IRQ_MASK: rd_value[IRQ_W-1:0] = irq_mask_reg;
            OFS_STATUS: begin
                rd_value[STS_PWR_BIT]  = balance_power_en;
                rd_value[STS_LOCK_BIT] = stop_lock;
                rd_value[STS_SQZ_BIT]  = open_wire_squeeze_enable;
            end
            default:      rd_value = '0;
        endcase
    end

    // sampled in the address phase so the data phase sees a flip-flop
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            hrdata <= '0;
        end else if (addr_ok && !hwrite) begin
            hrdata <= rd_value;
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    sequence s_fault_stop;
        !continue_on_fault && device_fault_in;
    endsequence

    sequence s_zero_write;
        wr_enable && hwdata[N_CELLS-1:0] == '0;
    endsequence

    sequence s_quiet_cycle;
        !wr_enable && !timer_expire && !wr_config;
    endsequence

    fault_stop_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        s_fault_stop |=> balance_enable_reg == '0 ##1 balance_drive_out == '0)
        else $error("fault did not clear the enable register");

    cksum_exempt_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        user_checksum_fault && !device_fault_in && !fault_flags_pending
        && !wr_enable && !timer_expire |=> $stable(balance_enable_reg))
        else $error("checksum fault disturbed balancing");

    stop_hold_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        stop_lock && wr_enable |=> balance_enable_reg == '0)
        else $error("enable write took effect during fault lockout");

    continue_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        continue_on_fault && device_fault_in ##0 s_quiet_cycle
        |=> $stable(balance_enable_reg) && $stable(continue_on_fault)
            && $stable(balance_time_field))
        else $error("fault changed registers with continue-on-fault set");

    cksum_flag_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        balance_enable_reg != $past(balance_enable_reg) |-> user_checksum_error_flag)
        else $error("enable change did not set the checksum error flag");

    power_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        balance_power_en == (balance_enable_reg != '0))
        else $error("power gate does not follow the enable register");

    zero_release_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        s_zero_write |=> !balance_power_en ##1 balance_drive_out == '0)
        else $error("zero write did not release the drivers");

    drive_follow_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
        wr_enable && !stop_lock |=> ##1 balance_drive_out == $past(hwdata[N_CELLS-1:0], 2))
        else $error("drivers do not follow the written enable bits");
endmodule : pcbc_balance_ctrl

// [pcbc_fet_model.sv]
// behavioural model of the external balancing n-fets, one across each cell
`timescale 1ns/10ps
module pcbc_fet_model
#(
    parameter int N = 16
) (
    // gate drive from the balance driver outputs
    input  wire logic [N-1:0] gate,
    // conduction state, 1 = balancing current flows
    output logic      [N-1:0] fet_on
);
    // ------------------------------------------------------------------
    // switching
    // ------------------------------------------------------------------
    // gate at upper rail turns the fet on, lower rail turns it off
    assign fet_on = gate;
endmodule : pcbc_fet_model

// [tb_pcbc_balance_ctrl.sv]
// self-checking bench for the passive cell balance control block
`timescale 1ns/10ps
module tb_pcbc_balance_ctrl
    import pcbc_pkg::*;
;
    localparam int TICK = 4;
    logic        sys_clk, reset_n, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        device_fault_in, fault_flags_pending, user_checksum_fault;
    logic [15:0] balance_drive_out, fet_on;
    logic        balance_power_en, user_checksum_error_flag, open_wire_squeeze_enable, irq;
    int          n_mismatch, n_checks;

    pcbc_balance_ctrl #(.N_CELLS(16), .TICK_LEN(TICK)) dut_u (
        .sys_clk(sys_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .device_fault_in(device_fault_in), .fault_flags_pending(fault_flags_pending),
        .user_checksum_fault(user_checksum_fault), .balance_drive_out(balance_drive_out),
        .balance_power_en(balance_power_en), .user_checksum_error_flag(user_checksum_error_flag),
        .open_wire_squeeze_enable(open_wire_squeeze_enable), .irq(irq));
    pcbc_fet_model #(.N(16)) fet_u (.gate(balance_drive_out), .fet_on(fet_on));

    // ------------------------------------------------------------------
    // bus and check tasks
    // ------------------------------------------------------------------
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : test_done

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // the master allows wait states: it waits for hready, but never for ever
    task automatic wait_ready();
        int i;
        i = 0;
        @(posedge sys_clk);
        while (hreadyout !== 1'b1) begin
            i++;
            if (i > 100) begin
                n_mismatch++;
                test_done();
            end
            @(posedge sys_clk);
        end
    endtask : wait_ready

    // entered just after a rising edge; returns at the edge that ends the data phase
    task automatic bus(input logic wr, input logic [7:0] ofs, input logic [31:0] wdat);
        haddr  <= {24'h000000, ofs};
        hwrite <= wr;
        htrans <= HTRANS_NONSEQ;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= wdat;
        wait_ready();
        rd = hrdata;
    endtask : bus

    task automatic wr(input logic [7:0] ofs, input logic [31:0] d);
        bus(1'b1, ofs, d);
    endtask : wr

    task automatic rchk(input string what, input logic [7:0] ofs, input logic [31:0] exp);
        bus(1'b0, ofs, 32'h00000000);
        chk(what, rd, exp);
        chk("hresp", hresp, 32'h0);
    endtask : rchk

    task automatic idle(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : idle

    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    initial begin
        reset_n = 1'b0; hsel = 1'b0; hwrite = 1'b0; haddr = 32'h0; hwdata = 32'h0;
        htrans = 2'h0; hsize = 3'h2; device_fault_in = 1'b0;
        fault_flags_pending = 1'b0; user_checksum_fault = 1'b0;
        n_mismatch = 0; n_checks = 0;
        repeat (10) @(posedge sys_clk);
        reset_n <= 1'b1;
        hsel    <= 1'b1;
        @(posedge sys_clk);
        chk("squeeze_rst", open_wire_squeeze_enable, 32'h1);
        rchk("test_cfg", OFS_TEST, 32'h00000001);
        wr(OFS_TEST, 32'h00000000);
        wr(OFS_ENABLE, 32'h00008001);
        idle(3);
        chk("drive_on", balance_drive_out, 32'h8001);
        chk("fet_on", fet_on, 32'h8001);
        chk("power_up", balance_power_en, 32'h1);
        chk("cksum_set", user_checksum_error_flag, 32'h1);
        wr(OFS_FAULT, 32'h00000002);
        idle(3);
        chk("cksum_clr", user_checksum_error_flag, 32'h0);
        wr(OFS_ENABLE, 32'h00000001);
        idle(3);
        chk("drive_off", balance_drive_out, 32'h0001);
        chk("cksum_chg", user_checksum_error_flag, 32'h1);
        rchk("status_pwr", OFS_STATUS, 32'h00000001);
        wr(OFS_ENABLE, 32'h00000000);
        idle(3);
        chk("drive_all_off", balance_drive_out, 32'h0);
        chk("power_down", balance_power_en, 32'h0);
        // checksum fault alone must not stop balancing
        wr(OFS_ENABLE, 32'h000000ff);
        user_checksum_fault <= 1'b1;
        idle(3);
        chk("cksum_flt_drive", balance_drive_out, 32'h00ff);
        rchk("fault_reg", OFS_FAULT, 32'h00000003);
        user_checksum_fault <= 1'b0;
        // continue-on-fault keeps everything running
        wr(OFS_CONFIG, 32'h00000301);
        device_fault_in <= 1'b1;
        idle(3);
        rchk("cont_enable", OFS_ENABLE, 32'h000000ff);
        rchk("cont_config", OFS_CONFIG, 32'h00000301);
        chk("cont_drive", balance_drive_out, 32'h00ff);
        // dropping continue-on-fault while the fault stands stops balancing
        wr(OFS_FAULT, 32'h00000002);
        wr(OFS_CONFIG, 32'h00000300);
        idle(3);
        chk("stop_drive", balance_drive_out, 32'h0);
        chk("stop_cksum", user_checksum_error_flag, 32'h1);
        rchk("stop_enable", OFS_ENABLE, 32'h00000000);
        rchk("stop_time_kept", OFS_CONFIG, 32'h00000300);
        rchk("stop_status", OFS_STATUS, 32'h00000002);
        device_fault_in     <= 1'b0;
        fault_flags_pending <= 1'b1;
        wr(OFS_ENABLE, 32'h00000f0f);
        idle(3);
        chk("flags_pending", balance_drive_out, 32'h0);
        fault_flags_pending <= 1'b0;
        wr(OFS_ENABLE, 32'h00000f0f);
        idle(3);
        chk("rewrite", balance_drive_out, 32'h0f0f);
        // balance time 3 ticks: expiry clears enable and flags the change
        wr(OFS_FAULT, 32'h00000002);
        for (int i = 0; i < 60 && balance_drive_out !== 16'h0000; i++) begin
            idle(1);
        end
        // an expiry that never comes ends the run as a failure
        if (balance_drive_out !== 16'h0000) begin
            n_mismatch++;
            test_done();
        end
        idle(2);
        chk("expired_drive", balance_drive_out, 32'h0);
        chk("expired_cksum", user_checksum_error_flag, 32'h1);
        // stop, expiry and enable change have all been latched by now
        rchk("irq_expired", OFS_IRQ_STAT, 32'h00000007);
        // interrupt on enable change: raised, cleared, masked
        wr(OFS_CONFIG, 32'h00000000);
        wr(OFS_IRQ_STAT, 32'h00000007);
        wr(OFS_IRQ_MASK, 32'h00000004);
        wr(OFS_ENABLE, 32'h00000005);
        idle(3);
        chk("irq_set", irq, 32'h1);
        wr(OFS_IRQ_STAT, 32'h00000004);
        idle(3);
        chk("irq_clr", irq, 32'h0);
        wr(OFS_IRQ_MASK, 32'h00000000);
        wr(OFS_ENABLE, 32'h00000000);
        idle(3);
        chk("irq_masked", irq, 32'h0);
        rchk("irq_stat", OFS_IRQ_STAT, 32'h00000004);
        wr(8'h20, 32'hffffffff);
        rchk("unmapped", 8'h20, 32'h00000000);
        test_done();
    end
endmodule : tb_pcbc_balance_ctrl
